// ---- hdl/vcps_defines.svh ----
`ifndef VCPS_DEFINES_SVH
`define VCPS_DEFINES_SVH

// System clock period and master clock watchdog
`define VCPS_CLK_NS          40
`define VCPS_MCLK_STOP_NS    2000
`define VCPS_MCLK_STOP_CYC   ((`VCPS_MCLK_STOP_NS) / (`VCPS_CLK_NS))

// Master clocks per frame sync period
`define VCPS_FRAME_MCLKS     9'h145

// Frames of output quiet time after power-up or clock loss
`define VCPS_WAKE_FRAMES     3'h4

// Word geometry
`define VCPS_LIN_BITS        5'h10
`define VCPS_CMP_BITS        5'h08
`define VCPS_LIN_LAST        4'hF
`define VCPS_CMP_LAST        4'h7
`define VCPS_LIN_PAD_FIRST   4'hD
`define VCPS_PAD_ZERO        3'h0
`define VCPS_CMP_FILL        8'h00
`define VCPS_ZERO_WORD       16'h0000

// Input synchroniser lane positions
`define VCPS_SYNC_W          11
`define VCPS_L_MCLK          0
`define VCPS_L_PWR           1
`define VCPS_L_TXFS          2
`define VCPS_L_RXFS          3
`define VCPS_L_TXBC          4
`define VCPS_L_RXBC          5
`define VCPS_L_DIN           6
`define VCPS_L_LIN           7
`define VCPS_L_MIC           8
`define VCPS_L_QUIET         9
`define VCPS_L_LOUD          10

`endif

// ---- hdl/vcps_frame_watch.sv ----
`timescale 1ns/1ps
`include "vcps_defines.svh"
module vcps_frame_watch import vcps_pkg::*; (
   input  wire logic clk,
   input  wire logic resetn,
   input  wire logic mclk_rise,
   input  wire logic sig_edge,
   output logic      held_low
);
   logic [8:0] cnt_reg;
   logic [8:0] cnt_next;
   logic       held_reg;
   logic       held_next;
   wire        at_limit = (cnt_reg == `VCPS_FRAME_MCLKS);

   // Stale once a full frame of master clocks passes with no edge
   assign cnt_next  = sig_edge ? 9'h000 :
                      (mclk_rise && !at_limit) ? cnt_reg + 9'h001 : cnt_reg;
   assign held_next = sig_edge ? 1'b0 : (held_reg | (mclk_rise & at_limit));

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         cnt_reg  <= 9'h000;
         held_reg <= 1'b1;
      end else begin
         cnt_reg  <= cnt_next;
         held_reg <= held_next;
      end
   end

   assign held_low = held_reg;

   a_stale_after_frame: assert property (@(posedge clk) disable iff (!resetn)
      (at_limit && mclk_rise && !sig_edge) |=> held_low)
      else $error("frame sync not marked held low after a silent frame");
endmodule // vcps_frame_watch

// ---- hdl/vcps_pkg.sv ----
package vcps_pkg;

   typedef enum logic [1:0] {
      VCPS_TX_IDLE,
      VCPS_TX_ARMED,
      VCPS_TX_SHIFT
   } vcps_tx_state_e;

   typedef enum logic {
      VCPS_RX_IDLE,
      VCPS_RX_SHIFT
   } vcps_rx_state_e;

   typedef logic [15:0] vcps_word_t;

endpackage

// ---- hdl/vcps_port.sv ----
`timescale 1ns/1ps
`include "vcps_defines.svh"
module vcps_port import vcps_pkg::*; (
   input  wire logic        clk,
   input  wire logic        resetn,
   input  wire logic        master_clk,
   input  wire logic        power_down_n,
   input  wire logic        tx_frame_sync,
   input  wire logic        rx_frame_sync,
   input  wire logic        tx_bit_clock,
   input  wire logic        rx_bit_clock,
   input  wire logic        serial_in,
   input  wire logic        linear_mode,
   input  wire logic        mic_silence_in,
   input  wire logic        tx_level_quiet,
   input  wire logic        tx_level_loud,
   input  wire logic [7:0]  tx_companded_sample_bits,
   input  wire logic [12:0] tx_linear_sample_bits,
   output logic             serial_out,
   output logic             serial_out_oe,
   output logic             tx_slot_strobe_n,
   output logic             tx_slot_strobe_oe,
   output logic             tx_sample_take,
   output logic [7:0]       rx_companded_sample_bits,
   output logic [12:0]      rx_linear_sample_bits,
   output logic [2:0]       rx_attenuation_field,
   output logic [4:0]       rx_attenuation_db,
   output logic             rx_word_valid,
   output logic             tx_standby,
   output logic             rx_standby,
   output logic             variable_timing
);
   // Pin synchronisers
   logic [`VCPS_SYNC_W-1:0] s_lvl;
   logic [`VCPS_SYNC_W-1:0] s_rise;
   logic [`VCPS_SYNC_W-1:0] s_fall;

   vcps_sync #(.W(`VCPS_SYNC_W)) u_sync (
      .clk    (clk),
      .resetn (resetn),
      .din    ({tx_level_loud, tx_level_quiet, mic_silence_in, linear_mode, serial_in,
                rx_bit_clock, tx_bit_clock, rx_frame_sync, tx_frame_sync, power_down_n,
                master_clk}),
      .level  (s_lvl),
      .rise   (s_rise),
      .fall   (s_fall)
   );

   wire mclk_rise = s_rise[`VCPS_L_MCLK];
   wire mclk_fall = s_fall[`VCPS_L_MCLK];
   wire pwr_on    = s_lvl[`VCPS_L_PWR];
   wire txfs_lvl  = s_lvl[`VCPS_L_TXFS];
   wire txfs_rise = s_rise[`VCPS_L_TXFS];
   wire rxfs_lvl  = s_lvl[`VCPS_L_RXFS];
   wire rxfs_rise = s_rise[`VCPS_L_RXFS];
   wire rxfs_fall = s_fall[`VCPS_L_RXFS];
   wire txbc_rise = s_rise[`VCPS_L_TXBC];
   wire txbc_fall = s_fall[`VCPS_L_TXBC];
   wire rxbc_lvl  = s_lvl[`VCPS_L_RXBC];
   wire rxbc_edge = s_rise[`VCPS_L_RXBC] | s_fall[`VCPS_L_RXBC];
   wire rxbc_fall = s_fall[`VCPS_L_RXBC];
   wire din_lvl   = s_lvl[`VCPS_L_DIN];
   wire lin_lvl   = s_lvl[`VCPS_L_LIN];
   wire mic_lvl   = s_lvl[`VCPS_L_MIC];
   wire quiet_lvl = s_lvl[`VCPS_L_QUIET];
   wire loud_lvl  = s_lvl[`VCPS_L_LOUD];

   // Held-low detectors for both syncs, and a no-edge detector for the receive bit clock
   logic tx_held;
   logic rx_held;
   logic rxbc_still;

   vcps_frame_watch u_txfs_watch (
      .clk       (clk),
      .resetn    (resetn),
      .mclk_rise (mclk_rise),
      .sig_edge  (txfs_rise),
      .held_low  (tx_held)
   );
   vcps_frame_watch u_rxfs_watch (
      .clk       (clk),
      .resetn    (resetn),
      .mclk_rise (mclk_rise),
      .sig_edge  (rxfs_rise),
      .held_low  (rx_held)
   );
   vcps_frame_watch u_rxbc_watch (
      .clk       (clk),
      .resetn    (resetn),
      .mclk_rise (mclk_rise),
      .sig_edge  (rxbc_edge),
      .held_low  (rxbc_still)
   );

   // Bit clock parked high for a whole frame means fixed timing
   wire fixed_mode = rxbc_lvl & rxbc_still;

   // Master clock loss and start-up quiet time
   logic [5:0] stop_cnt_reg;
   logic [5:0] stop_cnt_next;
   logic [2:0] wake_cnt_reg;
   logic [2:0] wake_cnt_next;
   logic       mquiet_reg;
   logic       mquiet_next;
   logic       hush_reg;
   logic       hush_next;
   logic       vt_reg;

   wire mclk_stopped = (stop_cnt_reg == 6'(`VCPS_MCLK_STOP_CYC));
   wire wake_done    = (wake_cnt_reg == `VCPS_WAKE_FRAMES);
   wire live         = pwr_on & ~mclk_stopped;

   assign stop_cnt_next = (mclk_rise | mclk_fall) ? 6'h00 :
                          mclk_stopped ? stop_cnt_reg : stop_cnt_reg + 6'h01;
   assign wake_cnt_next = !live ? 3'h0 :
                          ((txfs_rise | rxfs_rise) && !wake_done) ? wake_cnt_reg + 3'h1 :
                          wake_cnt_reg;

   // Noise-floor mute with hysteresis: quiet sets, loud clears
   assign mquiet_next = quiet_lvl ? 1'b1 : (loud_lvl ? 1'b0 : mquiet_reg);

   wire tx_on = live & wake_done & ~tx_held;
   wire rx_on = live & ~rx_held;

   // Transmit path
   vcps_tx_state_e tx_st_reg;
   vcps_tx_state_e tx_st_next;
   vcps_word_t     tx_word_reg;
   vcps_word_t     tx_word_next;
   logic [3:0]     tx_idx_reg;
   logic [3:0]     tx_idx_next;
   logic           tx_lin_reg;
   logic           tx_lin_next;
   logic           tx_seen_fall_reg;
   logic           tx_seen_fall_next;
   logic           sout_reg;
   logic           sout_next;
   logic           soe_reg;
   logic           soe_next;
   logic           strb_reg;
   logic           strb_next;
   logic           strb_oe_reg;
   logic           take_reg;

   // Zero code replaces the sample when muted
   wire        tx_mute    = mic_lvl | (~lin_lvl & mquiet_reg);
   wire [15:0] tx_fresh   = tx_mute ? `VCPS_ZERO_WORD :
                            lin_lvl ? {tx_linear_sample_bits, `VCPS_PAD_ZERO} :
                            {tx_companded_sample_bits, `VCPS_CMP_FILL};
   wire        tx_load    = tx_on & txfs_rise;
   wire [3:0]  tx_last    = tx_lin_reg ? `VCPS_LIN_LAST : `VCPS_CMP_LAST;
   wire        tx_at_last = (tx_idx_reg == tx_last);
   wire [3:0]  tx_wrap    = tx_at_last ? 4'h0 : tx_idx_reg + 4'h1;
   // Bit index counts from the sign bit down
   wire        tx_bit_now = tx_word_reg[~tx_idx_reg];
   wire        tx_bit_adv = tx_word_reg[~tx_wrap];

   always_comb begin
      tx_st_next        = tx_st_reg;
      tx_word_next      = tx_word_reg;
      tx_idx_next       = tx_idx_reg;
      tx_lin_next       = tx_lin_reg;
      tx_seen_fall_next = tx_seen_fall_reg;
      sout_next         = sout_reg;
      soe_next          = soe_reg;
      strb_next         = 1'b1;
      if (!tx_on) begin
         tx_st_next = VCPS_TX_IDLE;
         soe_next   = 1'b0;
      end else if (tx_load) begin
         tx_word_next      = tx_fresh;
         tx_lin_next       = lin_lvl;
         tx_idx_next       = 4'h0;
         tx_seen_fall_next = 1'b0;
         if (fixed_mode) begin
            tx_st_next = VCPS_TX_ARMED;
         end else begin
            tx_st_next = VCPS_TX_SHIFT;
            sout_next  = tx_fresh[15];
            soe_next   = 1'b1;
         end
      end else if (fixed_mode) begin
         case (tx_st_reg)
            VCPS_TX_ARMED: begin
               if (mclk_rise) begin
                  tx_st_next = VCPS_TX_SHIFT;
                  sout_next  = tx_bit_now;
                  soe_next   = 1'b1;
                  strb_next  = 1'b0;
               end
            end
            VCPS_TX_SHIFT: begin
               strb_next = 1'b0;
               if (mclk_fall && tx_at_last) begin
                  tx_st_next = VCPS_TX_IDLE;
                  soe_next   = 1'b0;
                  strb_next  = 1'b1;
               end else if (mclk_rise && !tx_at_last) begin
                  tx_idx_next = tx_wrap;
                  sout_next   = tx_bit_adv;
               end
            end
            default: soe_next = 1'b0;
         endcase
      end else begin
         case (tx_st_reg)
            VCPS_TX_SHIFT: begin
               if (!txfs_lvl) begin
                  tx_st_next = VCPS_TX_IDLE;
                  soe_next   = 1'b0;
               end else begin
                  if (txbc_fall) begin
                     tx_seen_fall_next = 1'b1;
                  end
                  // The rise that comes with the sync does not advance
                  if (txbc_rise && tx_seen_fall_reg) begin
                     tx_idx_next = tx_wrap;
                     sout_next   = tx_bit_adv;
                  end
               end
            end
            default: begin
               tx_st_next = VCPS_TX_IDLE;
               soe_next   = 1'b0;
            end
         endcase
      end
   end

   // Receive path
   vcps_rx_state_e rx_st_reg;
   vcps_rx_state_e rx_st_next;
   vcps_word_t     rx_sh_reg;
   vcps_word_t     rx_sh_next;
   logic [4:0]     rx_cnt_reg;
   logic [4:0]     rx_cnt_next;
   logic           rx_lin_reg;
   logic           rx_lin_next;
   logic [7:0]     rx_cmp_reg;
   logic [12:0]    rx_lpcm_reg;
   logic [2:0]     rx_att_reg;
   logic [4:0]     rx_db_reg;
   logic           rx_val_reg;
   logic           rx_pub_lin;
   logic           rx_pub_cmp;

   wire        rx_sample = fixed_mode ? mclk_fall : (rxbc_fall & rxfs_lvl);
   wire [15:0] rx_shifted = {rx_sh_reg[14:0], din_lvl};
   wire [4:0]  rx_need    = rx_lin_reg ? `VCPS_LIN_BITS : `VCPS_CMP_BITS;
   wire        rx_full    = ((rx_cnt_reg + 5'h01) == rx_need);
   // Companded words in variable timing are the last eight bits
   wire        rx_var_end = ~fixed_mode & ~rx_lin_reg & rxfs_fall &
                            (rx_cnt_reg >= `VCPS_CMP_BITS);

   always_comb begin
      rx_st_next  = rx_st_reg;
      rx_sh_next  = rx_sh_reg;
      rx_cnt_next = rx_cnt_reg;
      rx_lin_next = rx_lin_reg;
      rx_pub_lin  = 1'b0;
      rx_pub_cmp  = 1'b0;
      if (!rx_on) begin
         rx_st_next = VCPS_RX_IDLE;
      end else if (rxfs_rise) begin
         rx_st_next  = VCPS_RX_SHIFT;
         rx_cnt_next = 5'h00;
         rx_lin_next = lin_lvl;
      end else begin
         case (rx_st_reg)
            VCPS_RX_SHIFT: begin
               if (rx_var_end) begin
                  rx_st_next = VCPS_RX_IDLE;
                  rx_pub_cmp = 1'b1;
               end else if (rx_sample) begin
                  rx_sh_next  = rx_shifted;
                  rx_cnt_next = rx_full ? rx_cnt_reg : rx_cnt_reg + 5'h01;
                  if (rx_lin_reg && rx_full) begin
                     rx_st_next = VCPS_RX_IDLE;
                     rx_pub_lin = 1'b1;
                  end else if (!rx_lin_reg && fixed_mode && rx_full) begin
                     rx_st_next = VCPS_RX_IDLE;
                     rx_pub_cmp = 1'b1;
                  end else if (!rx_lin_reg && !fixed_mode) begin
                     rx_cnt_next = rx_cnt_reg + 5'h01;
                  end
               end else if (!fixed_mode && !rxfs_lvl) begin
                  rx_st_next = VCPS_RX_IDLE;
               end
            end
            default: rx_st_next = VCPS_RX_IDLE;
         endcase
      end
   end

   wire [7:0] rx_cmp_word = fixed_mode ? rx_shifted[7:0] : rx_sh_reg[7:0];
   // Attenuation in dB is three times the field
   wire [4:0] rx_db_calc  = {rx_shifted[2:0], 1'b0} + {2'b00, rx_shifted[2:0]};

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         stop_cnt_reg <= 6'h00;
         wake_cnt_reg <= 3'h0;
         mquiet_reg   <= 1'b0;
         hush_reg     <= 1'b1;
         vt_reg       <= 1'b0;
      end else begin
         stop_cnt_reg <= stop_cnt_next;
         wake_cnt_reg <= wake_cnt_next;
         mquiet_reg   <= mquiet_next;
         hush_reg     <= hush_next;
         vt_reg       <= ~fixed_mode;
      end
   end
   assign hush_next = ~tx_on;

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         tx_st_reg        <= VCPS_TX_IDLE;
         tx_word_reg      <= `VCPS_ZERO_WORD;
         tx_idx_reg       <= 4'h0;
         tx_lin_reg       <= 1'b0;
         tx_seen_fall_reg <= 1'b0;
         sout_reg         <= 1'b0;
         soe_reg          <= 1'b0;
         strb_reg         <= 1'b1;
         strb_oe_reg      <= 1'b0;
         take_reg         <= 1'b0;
      end else begin
         tx_st_reg        <= tx_st_next;
         tx_word_reg      <= tx_word_next;
         tx_idx_reg       <= tx_idx_next;
         tx_lin_reg       <= tx_lin_next;
         tx_seen_fall_reg <= tx_seen_fall_next;
         sout_reg         <= sout_next;
         soe_reg          <= soe_next;
         strb_reg         <= strb_next;
         strb_oe_reg      <= tx_on;
         take_reg         <= tx_load;
      end
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         rx_st_reg   <= VCPS_RX_IDLE;
         rx_sh_reg   <= `VCPS_ZERO_WORD;
         rx_cnt_reg  <= 5'h00;
         rx_lin_reg  <= 1'b0;
         rx_cmp_reg  <= 8'h00;
         rx_lpcm_reg <= 13'h0000;
         rx_att_reg  <= 3'h0;
         rx_db_reg   <= 5'h00;
         rx_val_reg  <= 1'b0;
      end else begin
         rx_st_reg   <= rx_st_next;
         rx_sh_reg   <= rx_sh_next;
         rx_cnt_reg  <= rx_cnt_next;
         rx_lin_reg  <= rx_lin_next;
         rx_val_reg  <= rx_pub_lin | rx_pub_cmp;
         if (rx_pub_cmp) begin
            rx_cmp_reg <= rx_cmp_word;
         end
         // Volume taken fresh from every linear word
         if (rx_pub_lin) begin
            rx_lpcm_reg <= rx_shifted[15:3];
            rx_att_reg  <= rx_shifted[2:0];
            rx_db_reg   <= rx_db_calc;
         end
      end
   end

   assign serial_out               = sout_reg;
   assign serial_out_oe            = soe_reg;
   assign tx_slot_strobe_n         = strb_reg;
   assign tx_slot_strobe_oe        = strb_oe_reg;
   assign tx_sample_take           = take_reg;
   assign rx_companded_sample_bits = rx_cmp_reg;
   assign rx_linear_sample_bits    = rx_lpcm_reg;
   assign rx_attenuation_field     = rx_att_reg;
   assign rx_attenuation_db        = rx_db_reg;
   assign rx_word_valid            = rx_val_reg;
   assign tx_standby               = hush_reg;
   assign rx_standby               = rx_held;
   assign variable_timing          = vt_reg;

   default clocking cb @(posedge clk); endclocking
   default disable iff (!resetn);

   a_pdn_floats: assert property (!pwr_on |=> !serial_out_oe && !tx_slot_strobe_oe)
      else $error("outputs driven during power-down");
   a_full_standby: assert property ((tx_held && rx_held) |=> !serial_out_oe ##0 !rx_word_valid)
      else $error("outputs active in full standby");
   a_tx_standby: assert property (tx_held |=> !serial_out_oe && !tx_slot_strobe_oe)
      else $error("transmit side active with its sync held low");
   a_rx_standby: assert property (rx_held |=> rx_st_reg == VCPS_RX_IDLE)
      else $error("receive shifting in receive standby");
   a_pad_zeros: assert property ((serial_out_oe && tx_lin_reg && tx_idx_reg >= `VCPS_LIN_PAD_FIRST)
      |-> !serial_out)
      else $error("linear pad bits not zero");
   a_mute_zero: assert property ((tx_load && mic_lvl) |=> tx_word_reg == `VCPS_ZERO_WORD)
      else $error("mute did not force zero code");
   a_sign_first: assert property ((tx_load && !fixed_mode) |=> serial_out == $past(tx_fresh[15]))
      else $error("first bit out is not the sign bit");
   a_strobe_word: assert property (!tx_slot_strobe_n |-> serial_out_oe)
      else $error("slot strobe low without data driven");
   a_fixed_first: assert property ((tx_st_reg == VCPS_TX_ARMED && mclk_rise && tx_on && !tx_load)
      |=> !tx_slot_strobe_n && serial_out_oe)
      else $error("fixed timing first bit missed");
   a_db_steps: assert property (rx_word_valid |-> rx_attenuation_db == 5'(rx_attenuation_field * 3))
      else $error("attenuation not three dB per step");

   c_fixed_word: cover property (tx_st_reg == VCPS_TX_SHIFT && fixed_mode ##1 tx_st_reg == VCPS_TX_IDLE);
   c_var_repeat: cover property (!fixed_mode && tx_at_last && txbc_rise && tx_seen_fall_reg && txfs_lvl);
   c_rx_linear: cover property (rx_pub_lin);
   c_rx_var_cmp: cover property (rx_pub_cmp && !fixed_mode);
endmodule // vcps_port

// ---- hdl/vcps_sync.sv ----
`timescale 1ns/1ps
module vcps_sync import vcps_pkg::*; #(
   parameter int W = 1
) (
   input  wire logic         clk,
   input  wire logic         resetn,
   input  wire logic [W-1:0] din,
   output logic      [W-1:0] level,
   output logic      [W-1:0] rise,
   output logic      [W-1:0] fall
);
   logic [W-1:0] meta_reg;
   logic [W-1:0] level_reg;
   logic [W-1:0] last_reg;

   genvar i;
   generate
      for (i = 0; i < W; i++) begin : g_lane
         always_ff @(posedge clk or negedge resetn) begin
            if (!resetn) begin
               meta_reg[i]  <= 1'b0;
               level_reg[i] <= 1'b0;
               last_reg[i]  <= 1'b0;
            end else begin
               meta_reg[i]  <= din[i];
               level_reg[i] <= meta_reg[i];
               last_reg[i]  <= level_reg[i];
            end
         end
         // Edges only from the second and third stage
         assign rise[i] = level_reg[i] & ~last_reg[i];
         assign fall[i] = ~level_reg[i] & last_reg[i];
      end
   endgenerate

   assign level = level_reg;
endmodule // vcps_sync

// ---- testbench/tb_voice_codec_pcm_serial_port.sv ----
`timescale 1ns/1ps
module tb_voice_codec_pcm_serial_port import vcps_pkg::*;;
   typedef struct packed {
      logic lin; logic mic; logic quiet; logic [7:0] cmp; logic [12:0] lsb; logic [15:0] rxw;
   } vcps_row_s;
   logic        clk, resetn, power_down_n, linear_mode, mic_silence_in, tx_level_quiet, tx_level_loud;
   logic        master_clk, tx_frame_sync, rx_frame_sync, tx_bit_clock, rx_bit_clock, serial_in;
   logic        serial_out, serial_out_oe, tx_slot_strobe_n, tx_slot_strobe_oe, tx_sample_take;
   logic        rx_word_valid, tx_standby, rx_standby, variable_timing, tx_en, rx_en, var_mode;
   logic [7:0]  tx_companded_sample_bits, rx_companded_sample_bits;
   logic [12:0] tx_linear_sample_bits, rx_linear_sample_bits;
   logic [2:0]  rx_attenuation_field;
   logic [4:0]  rx_attenuation_db;
   logic [15:0] rx_word;
   logic [31:0] cap;
   int          ncap, nstb, frame_cnt, rxcnt, r, miscompares, samples_checked, ntake;
   vcps_word_t  etx;
   vcps_row_s   rows [5] = '{'{1'h0, 1'h0, 1'h0, 8'hA5, 13'h0000, 16'h003C},
                             '{1'h0, 1'h1, 1'h0, 8'h81, 13'h0000, 16'h00C3},
                             '{1'h0, 1'h0, 1'h1, 8'h7E, 13'h0000, 16'h0055},
                             '{1'h1, 1'h0, 1'h1, 8'h00, 13'h0FFF, 16'h8007},
                             '{1'h1, 1'h0, 1'h0, 8'h00, 13'h1ABC, 16'hF00D}};
   vcps_port u_dut (.*);
   vcps_dsp_model u_dsp (.*);
   always #20 clk = ~clk;
   always @(negedge clk) if (rx_word_valid === 1'h1) rxcnt++;
   always @(negedge clk) if (tx_sample_take === 1'h1) ntake++;
   task chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
      samples_checked++;
      if (got !== exp) begin
         miscompares++;
         $display("mismatch %s expected %h seen %h", nm, exp, got);
      end
   endtask
   task frames(input int f);
      int t;
      t = frame_cnt + f;
      wait (frame_cnt == t);
      @(negedge clk);
   endtask
   task print_verdict;
      $display("checks %0d mismatches %0d", samples_checked, miscompares);
      if (miscompares == 0 && samples_checked > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   // Whole run is about 32 frames; allow some slack before calling it a hang
   initial begin
      #(36 * 104000);
      miscompares++;
      print_verdict;
   end
   initial begin
      {clk, resetn, power_down_n, linear_mode, mic_silence_in, tx_level_quiet, tx_level_loud} = 7'h11;
      {tx_companded_sample_bits, tx_linear_sample_bits, rx_word} = '0;
      {tx_en, rx_en, var_mode, rxcnt, miscompares, samples_checked, ntake} = '0;
      {tx_en, rx_en} = 2'h3;
      repeat (8) @(negedge clk);
      chk("reset outputs", 4'hC, {tx_standby, rx_standby, serial_out_oe, tx_slot_strobe_oe});
      resetn = 1'h1;
      frames(5);
      foreach (rows[i]) begin
         {linear_mode, mic_silence_in, tx_level_quiet, tx_level_loud} = {rows[i][39:37], ~rows[i].quiet};
         {tx_companded_sample_bits, tx_linear_sample_bits, rx_word} = rows[i][36:0];
         frames(2);
         etx = rows[i].lin ? {rows[i].lsb, 3'h0} : {8'h00, rows[i].cmp};
         if (rows[i].mic || (rows[i].quiet && !rows[i].lin)) etx = 16'h0000;
         chk("tx bit count", rows[i].lin ? 16 : 8, ncap);
         chk("tx word", etx, cap[15:0]);
         chk("strobe low bits", ncap, nstb);
         if (rows[i].lin) begin
            chk("rx linear", rows[i].rxw[15:3], rx_linear_sample_bits);
            chk("rx field", rows[i].rxw[2:0], rx_attenuation_field);
            chk("rx db", rows[i].rxw[2:0] * 3, rx_attenuation_db);
         end
         else chk("rx companded", rows[i].rxw[7:0], rx_companded_sample_bits);
      end
      rx_en = 1'h0;
      frames(3);
      chk("tx only bits", 16, ncap);
      chk("standby flags", 2'h2, {rx_standby, tx_standby});
      {tx_en, rx_en, r} = {2'h1, rxcnt};
      frames(5);
      chk("tx floated", 3'h4, {tx_standby, serial_out_oe, tx_slot_strobe_oe});
      chk("rx continues", 1, rxcnt > r);
      rx_en = 1'h0;
      frames(2);
      chk("all standby", 3'h6, {tx_standby, rx_standby, serial_out_oe});
      {tx_en, rx_en, var_mode, rx_word} = {3'h7, 16'h5A5B};
      r = ntake;
      frames(3);
      chk("variable mode", 1, variable_timing);
      chk("repeated word", {etx, etx}, cap);
      chk("repeat bits", 32, ncap);
      chk("no strobe", 0, nstb);
      chk("rx variable", rx_word[15:3], rx_linear_sample_bits);
      chk("sample takes", 2, ntake - r);
      {linear_mode, tx_companded_sample_bits, rx_word} = {1'h0, 8'hC3, 16'h0096};
      frames(2);
      chk("repeated companded", 16'hC3C3, cap[15:0]);
      chk("companded repeat bits", 16, ncap);
      chk("rx variable companded", 8'h96, rx_companded_sample_bits);
      {power_down_n, r} = {1'h0, ntake};
      frames(2);
      chk("power down", 3'h4, {tx_standby, serial_out_oe, tx_slot_strobe_oe});
      chk("power down bits", 0, ncap);
      chk("power down takes", 0, ntake - r);
      print_verdict;
   end
endmodule // tb_voice_codec_pcm_serial_port

// ---- testbench/vcps_dsp_model.sv ----
`timescale 1ns/1ps
module vcps_dsp_model (
   output logic             master_clk,
   output logic             tx_frame_sync,
   output logic             rx_frame_sync,
   output logic             tx_bit_clock,
   output logic             rx_bit_clock,
   output logic             serial_in,
   input  wire logic        serial_out,
   input  wire logic        serial_out_oe,
   input  wire logic        tx_slot_strobe_n,
   input  wire logic        tx_slot_strobe_oe,
   input  wire logic        linear_mode,
   input  wire logic        tx_en,
   input  wire logic        rx_en,
   input  wire logic        var_mode,
   input  wire logic [15:0] rx_word,
   output logic      [31:0] cap,
   output int               ncap,
   output int               nstb,
   output int               frame_cnt
);
   int   n;
   logic bclk_on;
   assign n = linear_mode ? 16 : 8;
   // Bit clocks are gated copies of the master clock in variable mode and stand still between windows; fixed mode parks the receive bit clock high
   assign tx_bit_clock = var_mode & bclk_on & master_clk;
   assign rx_bit_clock = var_mode ? (bclk_on & master_clk) : 1'h1;
   initial begin
      {master_clk, tx_frame_sync, rx_frame_sync, bclk_on, serial_in} = 5'h00;
      {cap, ncap, nstb, frame_cnt} = '0;
      #13;
      forever begin
         for (int k = -1; k < 324; k++) begin
            master_clk = 1'h1;
            // Full word every frame, idle line toggles so no stale bit looks valid
            serial_in = (k >= 0 && k < n) ? rx_word[n-1-k] : ~serial_in;
            if (k == 40) frame_cnt++;
            #160;
            // Take the bit at the falling edge: the last bit floats soon after it
            if (serial_out_oe === 1'h1) begin
               cap = {cap[30:0], serial_out};
               ncap++;
            end
            if (tx_slot_strobe_oe === 1'h1 && tx_slot_strobe_n === 1'h0) nstb++;
            master_clk = 1'h0;
            #80;
            if (k == -1) begin
               {tx_frame_sync, rx_frame_sync, bclk_on} = {tx_en, rx_en, var_mode};
               {cap, ncap, nstb} = '0;
            end
            if (k == (var_mode ? 2*n-1 : 0)) {tx_frame_sync, bclk_on} = 2'h0;
            if (k == (var_mode ? n-1 : 0)) rx_frame_sync = 1'h0;
            #80;
         end
      end
   end
endmodule // vcps_dsp_model
